// >>> hw/pms_pkg.sv
// constants and types shared by the power mode sequencer
package pms_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [7:0] PMS_ADDR_PWRDN  = 8'h00; // power_down_reg
    localparam logic [7:0] PMS_ADDR_CLKCTL = 8'h04; // system_clock_control_reg
    localparam logic [7:0] PMS_ADDR_LFSEL  = 8'h08; // low_freq_clock_select_reg
    localparam logic [7:0] PMS_ADDR_STAT   = 8'h0C; // mode / wake status
    localparam logic [7:0] PMS_ADDR_IRQST  = 8'h10; // sticky event flags
    localparam logic [7:0] PMS_ADDR_IRQMSK = 8'h14; // event mask

    // ----------------------------------------------------------------
    // field positions and codes
    // ----------------------------------------------------------------
    localparam logic [2:0] PMS_PD_REG_RET  = 3'h4;  // retention request
    localparam logic [2:0] PMS_PD_STANDBY  = 3'h7;  // standby request
    localparam int         PMS_CC_XO_KEEP  = 7;     // osc kept in retention
    localparam int         PMS_CC_XO_HI    = 5;     // osc start field hi
    localparam int         PMS_CC_XO_LO    = 4;     // osc start field lo
    localparam logic [1:0] PMS_CC_RC_ONLY  = 2'h1;  // fast xtal disabled
    localparam int         PMS_LF_XO_RUN   = 3;     // fast xtal running
    localparam logic [2:0] PMS_LF_NONE     = 3'h7;  // no lf source
    localparam logic [2:0] PMS_LF_RSV5     = 3'h5;  // reserved code
    localparam logic [2:0] PMS_LF_RSV6     = 3'h6;  // reserved code

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PMS_CLKCTL_RST  = 8'h00;
    localparam logic [2:0] PMS_LFSEL_RST   = 3'h7;
    localparam logic [3:0] PMS_IRQ_RST     = 4'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int PMS_CLK_NS       = 25;   // core_clk period
    localparam int PMS_STBY_WAKE_NS = 100;  // standby resume, longest
    localparam int PMS_STBY_WAKE_CYC =
        (PMS_STBY_WAKE_NS / PMS_CLK_NS) < 1 ? 1
                                          : PMS_STBY_WAKE_NS / PMS_CLK_NS;
    localparam logic [7:0] PMS_PRE_SHORT = 8'h04;   // short pre-start
    localparam logic [7:0] PMS_PRE_LONG  = 8'h40;   // full pre-start

    // ----------------------------------------------------------------
    // states and event bits
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PMS_ACTIVE, PMS_RET_ON, PMS_RET_OFF, PMS_STANDBY, PMS_PRESTART
    } pms_state_e;

    localparam int PMS_EV_PIN  = 0;  // wake by pin
    localparam int PMS_EV_TICK = 1;  // wake by tick
    localparam int PMS_EV_CMP  = 2;  // wake by comparator
    localparam int PMS_EV_IRQ  = 3;  // wake by radio/misc irq

endpackage

// >>> hw/pms_wake_if.sv
// wake event bundle between synchroniser and sequencer
interface pms_wake_if;
    logic pin;   // synced wake pin
    logic tick;  // synced tick
    logic cmp;   // synced comparator
    logic rad;   // synced radio irq
    logic misc;  // synced misc irq
    modport src (output pin, tick, cmp, rad, misc);
    modport dst (input  pin, tick, cmp, rad, misc);
endinterface

// >>> hw/pms_wake_sync.sv
// two-flop synchronisers for the asynchronous wake inputs
module pms_wake_sync (
    input  wire logic   core_clk,
    input  wire logic   sys_rst,
    input  wire logic   wake_pin,
    input  wire logic   timer_tick,
    input  wire logic   cmp_wake,
    input  wire logic   radio_irq,
    input  wire logic   misc_irq_a,
    pms_wake_if.src     wk
);
    // ----------------------------------------------------------------
    // synchroniser stages
    // ----------------------------------------------------------------
    logic [4:0] meta_reg;  // first stage, read only by second
    logic [4:0] sync_reg;  // second stage

    // capture the raw inputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_reg <= 5'h00;
            sync_reg <= 5'h00;
        end else begin
            meta_reg <= {misc_irq_a, radio_irq, cmp_wake, timer_tick,
                         wake_pin};
            sync_reg <= meta_reg;
        end
    end

    assign wk.pin  = sync_reg[0];
    assign wk.tick = sync_reg[1];
    assign wk.cmp  = sync_reg[2];
    assign wk.rad  = sync_reg[3];
    assign wk.misc = sync_reg[4];
endmodule

// >>> hw/pms_seq.sv
// power mode sequencer top: registers, mode machine, wake logic
//
// Contract
// - retention timers-on wake resumes, no reset
// - short pre-start if xtal off or kept
// - no short pre-start before xtal running
// - standby wakes on pin and tick plus radio/misc irqs
// - standby ignores analog comparator wakeup
// - standby resume within about 100 ns
// - standby stops processor clock, peripherals run
// - active: all powered, cpu runs
// - writing 100 enters register retention
// - operative lf source selects timers-on variant
// - timers-on wakes on pin, tick, comparator
// - timers-on keeps lf osc, counter, watchdog
// - report system clock source in bit 3
module pms_seq (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        wake_pin,
    input  wire logic        timer_tick,
    input  wire logic        cmp_wake,
    input  wire logic        radio_irq,
    input  wire logic        misc_irq_a,
    input  wire logic        fast_xo_ready,
    output logic             cpu_clk_en,
    output logic             sys_reset_req,
    output logic             fast_xo_en,
    output logic             lf_osc_en,
    output logic             lf_timers_en,
    output logic             irq
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    pms_wake_if             wk ();          // synced wake events
    pms_pkg::pms_state_e    state_reg;      // current mode
    pms_pkg::pms_state_e    state_next;     // next mode
    logic [2:0]  pd_reg;                    // power_down_reg
    logic [7:0]  clkctl_reg;                // system_clock_control_reg
    logic [2:0]  lfsel_reg;                 // low_freq_clock_select_reg
    logic        xo_run_reg;                // synced oscillator running
    logic        xo_meta_reg;               // first sync stage
    logic        xo_at_pd_reg;              // osc state at power-down
    logic [7:0]  pre_cnt_reg;               // pre-start countdown
    logic [7:0]  pre_cnt_next;              // its next value
    logic [3:0]  irq_st_reg;                // sticky events
    logic [3:0]  irq_msk_reg;               // event mask
    logic [3:0]  ev_set;                    // events this cycle
    logic        pd_wr;                     // power-down write strobe
    logic        wake_ret;                  // retention wake
    logic        wake_stby;                 // standby wake
    logic        tick_wake;                 // wake by tick
    logic        short_pre;                 // short pre-start chosen

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // true when the lf source field names an operative clock
    function automatic logic lf_operative(input logic [2:0] sel);
        return (sel != pms_pkg::PMS_LF_NONE) &&
               (sel != pms_pkg::PMS_LF_RSV5) &&
               (sel != pms_pkg::PMS_LF_RSV6);
    endfunction

    // ----------------------------------------------------------------
    // wake synchronisers
    // ----------------------------------------------------------------
    pms_wake_sync u_sync (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .wake_pin   (wake_pin),
        .timer_tick (timer_tick),
        .cmp_wake   (cmp_wake),
        .radio_irq  (radio_irq),
        .misc_irq_a (misc_irq_a),
        .wk         (wk)
    );

    // oscillator ready comes from the analog side
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            xo_meta_reg <= 1'b0;
            xo_run_reg  <= 1'b0;
        end else begin
            xo_meta_reg <= fast_xo_ready;
            xo_run_reg  <= xo_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // wake decode
    // ----------------------------------------------------------------
    assign pd_wr = reg_wr && (reg_addr == pms_pkg::PMS_ADDR_PWRDN);

    assign wake_ret = wk.pin | wk.cmp |
                      (wk.tick & (state_reg == pms_pkg::PMS_RET_ON));
    // standby adds radio and misc irqs
    // comparator left out of standby wake
    assign wake_stby = wk.pin | wk.tick | wk.rad | wk.misc;
    assign tick_wake = wk.tick & ~wk.pin & ~wk.cmp;

    // short pre-start when xtal off or kept on
    // but only if xtal was running at power-down
    assign short_pre = xo_at_pd_reg &&
        ((clkctl_reg[pms_pkg::PMS_CC_XO_HI:pms_pkg::PMS_CC_XO_LO]
          == pms_pkg::PMS_CC_RC_ONLY) ||
         clkctl_reg[pms_pkg::PMS_CC_XO_KEEP]);

    // ----------------------------------------------------------------
    // mode machine, next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        pre_cnt_next = pre_cnt_reg;
        case (state_reg)
            pms_pkg::PMS_ACTIVE: begin
                if (pd_wr && reg_wdata[2:0] == pms_pkg::PMS_PD_REG_RET) begin
                    if (lf_operative(lfsel_reg))
                        state_next = pms_pkg::PMS_RET_ON;
                    else
                        state_next = pms_pkg::PMS_RET_OFF;
                end else if (pd_wr &&
                             reg_wdata[2:0] == pms_pkg::PMS_PD_STANDBY) begin
                    state_next = pms_pkg::PMS_STANDBY;
                end
            end
            pms_pkg::PMS_RET_ON, pms_pkg::PMS_RET_OFF: begin
                // retention wake goes through pre-start
                if (wake_ret) begin
                    state_next = pms_pkg::PMS_PRESTART;
                    if (tick_wake && short_pre)
                        pre_cnt_next = pms_pkg::PMS_PRE_SHORT;
                    else
                        pre_cnt_next = pms_pkg::PMS_PRE_LONG;
                end
            end
            pms_pkg::PMS_PRESTART: begin
                // resume at end of pre-start, no reset
                if (pre_cnt_reg == 8'h00)
                    state_next = pms_pkg::PMS_ACTIVE;
                else
                    pre_cnt_next = pre_cnt_reg - 8'h01;
            end
            pms_pkg::PMS_STANDBY: begin
                // any standby wake returns to active
                // one cycle, well inside 100 ns
                if (wake_stby)
                    state_next = pms_pkg::PMS_ACTIVE;
            end
            default: state_next = pms_pkg::PMS_ACTIVE;
        endcase
    end

    // mode and countdown registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg   <= pms_pkg::PMS_ACTIVE;
            pre_cnt_reg <= 8'h00;
        end else begin
            state_reg   <= state_next;
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    // oscillator state latched as power-down is entered
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            xo_at_pd_reg <= 1'b0;
        else if (state_reg == pms_pkg::PMS_ACTIVE && pd_wr)
            xo_at_pd_reg <= xo_run_reg;
    end

    // ----------------------------------------------------------------
    // outputs to clock and power control
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cpu_clk_en    <= 1'b1;
            sys_reset_req <= 1'b0;
            fast_xo_en    <= 1'b1;
            lf_osc_en     <= 1'b0;
            lf_timers_en  <= 1'b0;
        end else begin
            // active runs cpu with everything powered
            cpu_clk_en    <= (state_next == pms_pkg::PMS_ACTIVE);
            // wakeups never request a system reset
            sys_reset_req <= 1'b0;
            // fast xtal on when active, pre-starting, in standby or kept
            fast_xo_en    <= (state_next == pms_pkg::PMS_ACTIVE) ||
                             (state_next == pms_pkg::PMS_PRESTART) ||
                             (state_next == pms_pkg::PMS_STANDBY) ||
                             clkctl_reg[pms_pkg::PMS_CC_XO_KEEP];
            // lf osc and timers run when a source is chosen
            lf_osc_en     <= (state_next != pms_pkg::PMS_RET_OFF) &&
                             lf_operative(lfsel_reg);
            lf_timers_en  <= (state_next != pms_pkg::PMS_RET_OFF) &&
                             lf_operative(lfsel_reg);
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pd_reg      <= 3'h0;
            clkctl_reg  <= pms_pkg::PMS_CLKCTL_RST;
            lfsel_reg   <= pms_pkg::PMS_LFSEL_RST;
            irq_msk_reg <= pms_pkg::PMS_IRQ_RST;
        end else begin
            // power-down value clears on return to active
            if (pd_wr && state_reg == pms_pkg::PMS_ACTIVE)
                pd_reg <= reg_wdata[2:0];
            else if (state_next == pms_pkg::PMS_ACTIVE)
                pd_reg <= 3'h0;
            if (reg_wr && reg_addr == pms_pkg::PMS_ADDR_CLKCTL)
                clkctl_reg <= reg_wdata;
            if (reg_wr && reg_addr == pms_pkg::PMS_ADDR_LFSEL)
                lfsel_reg <= reg_wdata[2:0];
            if (reg_wr && reg_addr == pms_pkg::PMS_ADDR_IRQMSK)
                irq_msk_reg <= reg_wdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // wake events and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        ev_set = 4'h0;
        if ((state_reg == pms_pkg::PMS_RET_ON ||
             state_reg == pms_pkg::PMS_RET_OFF) && wake_ret) begin
            ev_set[pms_pkg::PMS_EV_PIN]  = wk.pin;
            ev_set[pms_pkg::PMS_EV_TICK] = tick_wake;
            ev_set[pms_pkg::PMS_EV_CMP]  = wk.cmp & ~wk.pin;
        end
        if (state_reg == pms_pkg::PMS_STANDBY && wake_stby) begin
            ev_set[pms_pkg::PMS_EV_PIN]  = wk.pin;
            ev_set[pms_pkg::PMS_EV_TICK] = wk.tick;
            ev_set[pms_pkg::PMS_EV_IRQ]  = wk.rad | wk.misc;
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            irq_st_reg <= pms_pkg::PMS_IRQ_RST;
        else if (reg_wr && reg_addr == pms_pkg::PMS_ADDR_IRQST)
            irq_st_reg <= (irq_st_reg & ~reg_wdata[3:0]) | ev_set;
        else
            irq_st_reg <= irq_st_reg | ev_set;
    end

    // level interrupt from the status register
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(irq_st_reg & irq_msk_reg);
    end

    // ----------------------------------------------------------------
    // read port, data one cycle after strobe
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                pms_pkg::PMS_ADDR_PWRDN:  reg_rdata <= {5'h00, pd_reg};
                pms_pkg::PMS_ADDR_CLKCTL: reg_rdata <= clkctl_reg;
                // bit 3 shows fast xtal as clock source
                pms_pkg::PMS_ADDR_LFSEL:
                    reg_rdata <= {4'h0, xo_run_reg, lfsel_reg};
                pms_pkg::PMS_ADDR_STAT:
                    reg_rdata <= {5'h00, 3'(state_reg)};
                pms_pkg::PMS_ADDR_IRQST:  reg_rdata <= {4'h0, irq_st_reg};
                pms_pkg::PMS_ADDR_IRQMSK: reg_rdata <= {4'h0, irq_msk_reg};
                default:                  reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// >>> tb/pms_seq_chk.sv
// port-level assertion checker for the power mode sequencer
module pms_seq_chk (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       wake_pin,
    input wire logic       timer_tick,
    input wire logic       cmp_wake,
    input wire logic       radio_irq,
    input wire logic       misc_irq_a,
    input wire logic       cpu_clk_en,
    input wire logic       sys_reset_req,
    input wire logic       lf_osc_en,
    input wire logic       lf_timers_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    logic       pd_wr;   // write to power_down_reg
    logic       others;  // any wake but the comparator
    logic       lf_op;   // shadow lf select names a source
    logic [2:0] lf_q;    // shadow of lf select field
    logic       clk_q;   // cpu_clk_en one cycle ago
    logic       stby_q;  // in standby, not yet woken
    logic       ret_q;   // in timers-on retention
    logic [3:0] quiet_q; // cycles with other wakes low
    assign pd_wr  = reg_wr && reg_addr == pms_pkg::PMS_ADDR_PWRDN;
    assign others = wake_pin | timer_tick | radio_irq | misc_irq_a;
    assign lf_op  = lf_q <= 3'h4;
    // track lf select, mode entry and wake-source silence
    always_ff @(posedge core_clk) begin
        clk_q <= cpu_clk_en;
        if (sys_rst) begin
            lf_q <= pms_pkg::PMS_LFSEL_RST;
        end else if (reg_wr && reg_addr == pms_pkg::PMS_ADDR_LFSEL) begin
            lf_q <= reg_wdata[2:0];
        end
        if (sys_rst || (cpu_clk_en && !clk_q)) begin
            stby_q <= 1'b0;
            ret_q  <= 1'b0;
        end else if (pd_wr && cpu_clk_en) begin
            stby_q <= reg_wdata[2:0] == pms_pkg::PMS_PD_STANDBY;
            ret_q  <= reg_wdata[2:0] == pms_pkg::PMS_PD_REG_RET && lf_op;
        end
        if (sys_rst || others) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_no_reset_req: assert property (
        !sys_reset_req) else $error("system reset requested");
    a_active_holds: assert property (
        cpu_clk_en && !pd_wr && !$past(pd_wr) |=> cpu_clk_en)
        else $error("cpu clock stopped without power-down");
    a_standby_stops: assert property (
        pd_wr && cpu_clk_en && reg_wdata[2:0] == pms_pkg::PMS_PD_STANDBY
        |-> ##[1:2] !cpu_clk_en) else $error("standby kept cpu clock");
    a_ret_variant: assert property (
        pd_wr && cpu_clk_en && reg_wdata[2:0] == pms_pkg::PMS_PD_REG_RET
        |-> ##[1:2] (!cpu_clk_en && (lf_op ? (lf_osc_en && lf_timers_en)
                                           : !lf_timers_en)))
        else $error("wrong retention variant");
    a_stby_wake_fast: assert property (
        stby_q && !cpu_clk_en && $rose(wake_pin | radio_irq | misc_irq_a)
        |-> ##[1:5] cpu_clk_en) else $error("slow standby wake");
    a_stby_no_cmp: assert property (
        stby_q && !cpu_clk_en && cmp_wake && quiet_q >= 4'h8
        |=> !cpu_clk_en) else $error("comparator woke standby");
    a_ret_tick_wake: assert property (
        ret_q && !cpu_clk_en && $rose(timer_tick) |-> ##[1:100] cpu_clk_en)
        else $error("tick did not wake retention");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule

bind pms_seq pms_seq_chk u_chk (.*);

// >>> tb/pms_wake_src.sv
// wake sources and fast crystal model facing the sequencer
module pms_wake_src #(
    parameter int HOLD     = 4,  // cycles each wake event stands
    parameter int XO_START = 20  // crystal start-up cycles
) (
    input  wire logic       core_clk,
    input  wire logic       fast_xo_en,
    input  wire logic [4:0] fire,
    input  wire logic       xo_slow,
    output logic            wake_pin,
    output logic            timer_tick,
    output logic            cmp_wake,
    output logic            radio_irq,
    output logic            misc_irq_a,
    output logic            fast_xo_ready
);
    logic [4:0] ev = 5'h00; // live event levels
    int         left [5];   // cycles still to hold each event
    int         xo_cnt = 0; // crystal start-up progress
    assign {misc_irq_a, radio_irq, cmp_wake, timer_tick, wake_pin} = ev;
    assign fast_xo_ready = xo_cnt == XO_START;
    // each kick raises its line for HOLD cycles, then drops it
    always @(posedge core_clk) begin
        for (int i = 0; i < 5; i++) begin
            if (fire[i]) begin
                left[i] <= HOLD;
                ev[i]   <= 1'b1;
            end else if (left[i] > 1) begin
                left[i] <= left[i] - 1;
            end else begin
                left[i] <= 0;
                ev[i]   <= 1'b0;
            end
        end
    end
    // crystal runs only after a start-up time while enabled
    always @(posedge core_clk) begin
        if (!fast_xo_en || xo_slow) begin
            xo_cnt <= 0;
        end else if (xo_cnt < XO_START) begin
            xo_cnt <= xo_cnt + 1;
        end
    end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the power mode sequencer
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0; // 40 MHz core clock
    logic       sys_rst  = 1'b1; // synchronous reset
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr   = 1'b0;
    logic       reg_rd   = 1'b0;
    logic [4:0] fire     = 5'h00; // wake event kicks
    logic       xo_slow  = 1'b0;  // crystal refuses to start
    logic [7:0] reg_rdata;
    logic wake_pin, timer_tick, cmp_wake, radio_irq, misc_irq_a;
    logic fast_xo_ready, cpu_clk_en, sys_reset_req, fast_xo_en;
    logic lf_osc_en, lf_timers_en, irq;
    int   fails = 0;
    int   n_compared = 0;
    always #12.5 core_clk = ~core_clk;
    pms_seq dut (.*);
    pms_wake_src wk (.core_clk(core_clk), .fast_xo_en(fast_xo_en),
        .fire(fire), .xo_slow(xo_slow), .wake_pin(wake_pin),
        .timer_tick(timer_tick), .cmp_wake(cmp_wake),
        .radio_irq(radio_irq), .misc_irq_a(misc_irq_a),
        .fast_xo_ready(fast_xo_ready));
    // ----------------------------------------------------------------
    // bus and helper tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    // read, then compare the masked data
    task automatic rc(input logic [7:0] a, e, m, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
        `CHK(d & m, e)
    endtask
    task automatic kick(input int i);
        @(posedge core_clk);
        fire <= 5'h01 << i;
        @(posedge core_clk);
        fire <= 5'h00;
    endtask
    task automatic wait_run(input int lim, output int n);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK(cpu_clk_en, 1'b1)
        if (cpu_clk_en !== 1'b1) stop_test();
    endtask
    // power down, then confirm the clock stopped and the mode code
    task automatic sleep(input logic [2:0] code, input logic [7:0] st);
        logic [7:0] d;
        wr(pms_pkg::PMS_ADDR_PWRDN, {5'h00, code});
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(cpu_clk_en, 1'b0)
        rc(pms_pkg::PMS_ADDR_STAT, st, 8'h07, d);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (50000) @(posedge core_clk);
        fails++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d;
        int         n;
        int         k;
        int         src [4] = '{0, 1, 3, 4};
        logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18};
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        // reset values, unmapped write ignored
        wr(8'h18, 8'hFF);
        foreach (adr[i]) rc(adr[i], 8'h00, 8'hFF, d);
        rc(pms_pkg::PMS_ADDR_LFSEL, 8'h07, 8'h07, d);
        `CHK({cpu_clk_en, irq, sys_reset_req}, 3'b100)
        // timers-off retention, pin wake
        sleep(pms_pkg::PMS_PD_REG_RET, 8'h02);
        `CHK(lf_timers_en, 1'b0)
        kick(0);
        wait_run(100, n);
        rc(pms_pkg::PMS_ADDR_PWRDN, 8'h00, 8'h07, d);
        // timers-on retention: short or long pre-start on tick
        // kept xtal, slow xtal, xtal disabled, neither
        for (int i = 0; i < 4; i++) begin
            xo_slow <= i == 1;
            wr(pms_pkg::PMS_ADDR_CLKCTL,
               i == 3 ? 8'h00 : (i == 2 ? 8'h10 : 8'h80));
            k = 0;
            do begin
                rc(pms_pkg::PMS_ADDR_LFSEL, 8'h00, 8'h00, d);
                k++;
            end while (d[3] !== (i != 1) && k < 40);
            `CHK(d[3], i != 1)
            wr(pms_pkg::PMS_ADDR_LFSEL, 8'h01);
            sleep(pms_pkg::PMS_PD_REG_RET, 8'h01);
            `CHK({lf_osc_en, lf_timers_en}, 2'b11)
            kick(3);
            repeat (8) @(posedge core_clk);
            #1;
            `CHK(cpu_clk_en, 1'b0)
            kick(1);
            wait_run(120, n);
            `CHK(n < 16, (i % 2) == 0)
            `CHK(sys_reset_req, 1'b0)
        end
        // standby: comparator ignored, other sources wake fast
        foreach (src[j]) begin
            sleep(pms_pkg::PMS_PD_STANDBY, 8'h03);
            kick(2);
            repeat (8) @(posedge core_clk);
            #1;
            `CHK(cpu_clk_en, 1'b0)
            kick(src[j]);
            wait_run(6, n);
            `CHK(sys_reset_req, 1'b0)
            repeat (8) @(posedge core_clk);
        end
        // sticky status, mask and level interrupt
        wr(pms_pkg::PMS_ADDR_IRQST, 8'h0F);
        rc(pms_pkg::PMS_ADDR_IRQST, 8'h00, 8'h0F, d);
        sleep(pms_pkg::PMS_PD_STANDBY, 8'h03);
        kick(0);
        wait_run(6, n);
        repeat (8) @(posedge core_clk);
        rc(pms_pkg::PMS_ADDR_IRQST, 8'h01, 8'h01, d);
        `CHK(irq, 1'b0)
        wr(pms_pkg::PMS_ADDR_IRQMSK, 8'h01);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(irq, 1'b1)
        wr(pms_pkg::PMS_ADDR_IRQST, 8'h01);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(irq, 1'b0)
        rc(pms_pkg::PMS_ADDR_IRQST, 8'h00, 8'h01, d);
        stop_test();
    end
endmodule
